// ### src/psr_pkg.sv
// package: shared constants and types of the packed register file
`default_nettype none
package psr_pkg;
    localparam int NUM_REGS = 8;
    localparam int REG_W = 64;
    localparam int IDX_W = 3;
    localparam int HALF_W = 32;
    localparam logic [63:0] REG_RESET = 64'h0000_0000_0000_0000;
    localparam logic [7:0] SB_MAX = 8'h7f;
    localparam logic [7:0] SB_MIN = 8'h80;
    localparam logic [15:0] SW_MAX = 16'h7fff;
    localparam logic [15:0] SW_MIN = 16'h8000;
    localparam logic [31:0] SD_MAX = 32'h7fff_ffff;
    localparam logic [31:0] SD_MIN = 32'h8000_0000;

    // lane width selection
    typedef enum logic [1:0] {
        PSR_LANE_B = 2'h0,
        PSR_LANE_W = 2'h1,
        PSR_LANE_D = 2'h2,
        PSR_LANE_Q = 2'h3
    } psr_lane_t;

    // operation codes of the lane datapath
    typedef enum logic [3:0] {
        PSR_OP_ADD = 4'h0,
        PSR_OP_SUB = 4'h1,
        PSR_OP_ADDS = 4'h2,
        PSR_OP_SUBS = 4'h3,
        PSR_OP_ADDUS = 4'h4,
        PSR_OP_SUBUS = 4'h5,
        PSR_OP_AND = 4'h6,
        PSR_OP_ANDN = 4'h7,
        PSR_OP_OR = 4'h8,
        PSR_OP_XOR = 4'h9,
        PSR_OP_CMPEQ = 4'ha,
        PSR_OP_CMPGT = 4'hb
    } psr_op_t;
endpackage : psr_pkg
`default_nettype wire

// ### src/psr_alu_if.sv
// interface: operands and result between register file and lane datapath
`default_nettype none
interface psr_alu_if;
    logic [63:0] src_a;
    logic [63:0] src_b;
    psr_pkg::psr_op_t op;
    psr_pkg::psr_lane_t lane;
    logic [63:0] result;
    modport rf (output src_a, output src_b, output op, output lane,
        input result);
    modport alu (input src_a, input src_b, input op, input lane,
        output result);
endinterface : psr_alu_if
`default_nettype wire

// ### src/psr_lane_alu.sv
// lane datapath: byte, word and doubleword lanes computed in parallel
`default_nettype none
module psr_lane_alu
(
    psr_alu_if.alu bus
);
    // ***************************************************************
    // per-lane slices; byte, word and doubleword widths each have their own generate loop
    // ***************************************************************
    logic [63:0] res_b;
    logic [63:0] res_w;
    logic [63:0] res_d;
    logic [63:0] res_q;

    // one function computes one lane of any width up to 32 bits
    function automatic logic [31:0] lane_op(input logic [31:0] a,
        input logic [31:0] b, input int w, input psr_pkg::psr_op_t op);
        logic [32:0] sum;
        logic [32:0] dif;
        logic [31:0] mask;
        logic [31:0] smax;
        logic [31:0] r;
        logic sa;
        logic sb;
        logic ss;
        logic sd;
        mask = 32'hffff_ffff >> (32 - w);
        smax = mask >> 1;
        sum = {1'b0, a & mask} + {1'b0, b & mask};
        dif = {1'b0, a & mask} - {1'b0, b & mask};
        sa = a[w-1];
        sb = b[w-1];
        ss = sum[w-1];
        sd = dif[w-1];
        r = 32'h0000_0000;
        unique case (op)
            psr_pkg::PSR_OP_ADD: r = sum[31:0];
            psr_pkg::PSR_OP_SUB: r = dif[31:0];
            psr_pkg::PSR_OP_ADDS:
                if (sa == sb && ss != sa)
                    r = sa ? ~smax : smax;
                else
                    r = sum[31:0];
            psr_pkg::PSR_OP_SUBS:
                if (sa != sb && sd != sa)
                    r = sa ? ~smax : smax;
                else
                    r = dif[31:0];
            psr_pkg::PSR_OP_ADDUS: r = sum[w] ? mask : sum[31:0];
            psr_pkg::PSR_OP_SUBUS: r = dif[w] ? 32'h0000_0000 : dif[31:0];
            psr_pkg::PSR_OP_AND: r = a & b;
            psr_pkg::PSR_OP_ANDN: r = ~a & b;
            psr_pkg::PSR_OP_OR: r = a | b;
            psr_pkg::PSR_OP_XOR: r = a ^ b;
            psr_pkg::PSR_OP_CMPEQ:
                r = ((a & mask) == (b & mask)) ? mask : 32'h0000_0000;
            psr_pkg::PSR_OP_CMPGT:
                r = ((sa != sb) ? sb : (dif[w-1] == 1'b0 && dif[31:0] != 0))
                    ? mask : 32'h0000_0000;
            default: r = 32'h0000_0000;
        endcase
        return r & mask;
    endfunction : lane_op

    // each lane sees only its own bits, so no carry crosses lanes
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_byte
            assign res_b[g*8 +: 8] = 8'(lane_op({24'h00_0000,
                bus.src_a[g*8 +: 8]}, {24'h00_0000, bus.src_b[g*8 +: 8]},
                8, bus.op));
        end
        for (g = 0; g < 4; g++)
        begin : g_word
            assign res_w[g*16 +: 16] = 16'(lane_op({16'h0000,
                bus.src_a[g*16 +: 16]}, {16'h0000, bus.src_b[g*16 +: 16]},
                16, bus.op));
        end
        for (g = 0; g < 2; g++)
        begin : g_dword
            assign res_d[g*32 +: 32] = lane_op(bus.src_a[g*32 +: 32],
                bus.src_b[g*32 +: 32], 32, bus.op);
        end
    endgenerate

    // quadword view: logical operations on the whole container, a 64-bit add for every other op
    always_comb
    begin
        unique case (bus.op)
            psr_pkg::PSR_OP_AND: res_q = bus.src_a & bus.src_b;
            psr_pkg::PSR_OP_ANDN: res_q = ~bus.src_a & bus.src_b;
            psr_pkg::PSR_OP_OR: res_q = bus.src_a | bus.src_b;
            psr_pkg::PSR_OP_XOR: res_q = bus.src_a ^ bus.src_b;
            default: res_q = bus.src_a + bus.src_b;
        endcase
    end

    // lane width chosen by the lane select
    always_comb
    begin
        unique case (bus.lane)
            psr_pkg::PSR_LANE_B: bus.result = res_b;
            psr_pkg::PSR_LANE_W: bus.result = res_w;
            psr_pkg::PSR_LANE_D: bus.result = res_d;
            psr_pkg::PSR_LANE_Q: bus.result = res_q;
        endcase
    end
endmodule : psr_lane_alu
`default_nettype wire

// ### src/psr_regfile.sv
// packed register file with shared floating-point view and lane datapath
// Notes on behaviour
// - eight 64-bit packed registers, selected directly by index
// - register contents never leave as a memory address
// - packed and fp stack views share one storage array
// - a value reads as byte, word, doubleword or quadword lanes
// - full width moves carry the whole 64-bit container unchanged
// - all lanes compute in parallel and independently
// - signed and unsigned lane interpretations are both supported
// - signed saturating byte add combines eight byte pairs into dest
// - stores put the least significant lane at the lowest address
// - register bit layout equals the memory layout of the quantity
// - full width mode for 64-bit moves and all arithmetic
// - half width mode for 32-bit memory and integer moves
// - no new mode or system-visible state is added
// - memory operands addressed by the core, not by this block
// - the instruction set has 57 instructions in seven groups
// - saturating byte, word and doubleword lanes clamp to the type maximum or minimum
// - wraparound lanes keep low bits and drop the carry
// - overflow raises no exception and sets no flag
`default_nettype none
module psr_regfile
#(
    parameter int NREG = psr_pkg::NUM_REGS
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // packed operation issue
    input wire logic op_valid,
    input wire psr_pkg::psr_op_t op_code,
    input wire psr_pkg::psr_lane_t op_lane,
    input wire logic [2:0] op_dst,
    input wire logic [2:0] op_src,
    input wire logic op_src_mem,
    input wire logic [63:0] op_mem_data,
    // move into a packed register
    input wire logic mv_valid,
    input wire logic mv_half,
    input wire logic [2:0] mv_dst,
    input wire logic [63:0] mv_data,
    // fp stack view write
    input wire logic fp_wr,
    input wire logic [2:0] fp_idx,
    input wire logic [63:0] fp_wdata,
    // read ports
    input wire logic [2:0] rd_idx,
    input wire logic rd_half,
    output logic [63:0] rd_data,
    output logic [7:0] rd_bytes [8],
    input wire logic [2:0] fp_rd_idx,
    output logic [63:0] fp_rd_data
);
    // ***************************************************************
    // storage
    // ***************************************************************
    logic [63:0] store_reg [NREG];
    psr_alu_if alu_bus ();

    // datapath operands: the source may come from memory
    assign alu_bus.src_a = store_reg[op_dst];
    assign alu_bus.src_b = op_src_mem ? op_mem_data
        : store_reg[op_src];
    assign alu_bus.op = op_code;
    assign alu_bus.lane = op_lane;

    psr_lane_alu u_alu
    (
        .bus(alu_bus)
    );

    // ***************************************************************
    // write ports: operation first, then move, then fp view
    // ***************************************************************
    genvar g;
    generate
        for (g = 0; g < NREG; g++)
        begin : g_reg
            always_ff @(posedge clk)
            begin
                if (rst)
                    store_reg[g] <= psr_pkg::REG_RESET;
                else if (op_valid && op_dst == 3'(g))
                    store_reg[g] <= alu_bus.result;
                else if (mv_valid && mv_dst == 3'(g))
                    store_reg[g] <= mv_half ?
                        {32'h0000_0000, mv_data[31:0]} : mv_data;
                else if (fp_wr && fp_idx == 3'(g))
                    store_reg[g] <= fp_wdata;
            end
        end
    endgenerate

    // ***************************************************************
    // read ports; byte 0 is the lowest memory address
    // ***************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
            rd_data <= psr_pkg::REG_RESET;
        else
            rd_data <= rd_half ? {32'h0000_0000, store_reg[rd_idx][31:0]}
                : store_reg[rd_idx];
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            fp_rd_data <= psr_pkg::REG_RESET;
        else
            fp_rd_data <= store_reg[fp_rd_idx];
    end

    generate
        for (g = 0; g < 8; g++)
        begin : g_bytes
            always_ff @(posedge clk)
            begin
                if (rst)
                    rd_bytes[g] <= 8'h00;
                else
                    rd_bytes[g] <= store_reg[rd_idx][g*8 +: 8];
            end
        end
    endgenerate

    // ***************************************************************
    // checks
    // ***************************************************************
    a_sat_byte_hi: assert property (@(posedge clk) disable iff (rst)
        op_valid && op_code == psr_pkg::PSR_OP_ADDS &&
        op_lane == psr_pkg::PSR_LANE_B && !alu_bus.src_a[7] &&
        !alu_bus.src_b[7] && (9'(alu_bus.src_a[7:0]) +
        9'(alu_bus.src_b[7:0])) > 9'h07f
        |=> store_reg[$past(op_dst)][7:0] == psr_pkg::SB_MAX)
        else $error("signed byte add did not clamp high");
    a_sat_byte_lo: assert property (@(posedge clk) disable iff (rst)
        op_valid && op_code == psr_pkg::PSR_OP_ADDS &&
        op_lane == psr_pkg::PSR_LANE_B && alu_bus.src_a[63] &&
        alu_bus.src_b[63] && !alu_bus.result[63]
        |-> 1'b0)
        else $error("signed byte add wrapped negative lane");
    a_wrap_byte: assert property (@(posedge clk) disable iff (rst)
        op_valid && op_code == psr_pkg::PSR_OP_ADD &&
        op_lane == psr_pkg::PSR_LANE_B
        |-> alu_bus.result[15:8] ==
            8'(alu_bus.src_a[15:8] + alu_bus.src_b[15:8]))
        else $error("byte lane carry leaked");
    a_move_whole: assert property (@(posedge clk) disable iff (rst)
        mv_valid && !mv_half && !op_valid
        |=> store_reg[$past(mv_dst)] == $past(mv_data))
        else $error("quadword move altered");
    a_move_half: assert property (@(posedge clk) disable iff (rst)
        mv_valid && mv_half && !op_valid
        |=> store_reg[$past(mv_dst)][63:32] == 32'h0000_0000)
        else $error("half move did not clear upper half");
    a_fp_alias: assert property (@(posedge clk) disable iff (rst)
        fp_wr && !op_valid && !mv_valid
        |=> store_reg[$past(fp_idx)] == $past(fp_wdata))
        else $error("fp view write not seen in packed view");
    a_read_layout: assert property (@(posedge clk) disable iff (rst)
        1'b1 |-> rd_bytes[0] == $past(store_reg[rd_idx][7:0]))
        else $error("lowest byte not in lane zero");
    a_lane_word: assert property (@(posedge clk) disable iff (rst)
        op_valid && op_code == psr_pkg::PSR_OP_XOR &&
        op_lane == psr_pkg::PSR_LANE_W
        |-> alu_bus.result == (alu_bus.src_a ^ alu_bus.src_b))
        else $error("word xor lanes wrong");

    // lane arithmetic: wraparound, unsigned and signed clamping
    a_wrap_sub: assert property (@(posedge clk) disable iff (rst)
        op_valid && op_code == psr_pkg::PSR_OP_SUB &&
        op_lane == psr_pkg::PSR_LANE_B
        |-> alu_bus.result[7:0] ==
            8'(alu_bus.src_a[7:0] - alu_bus.src_b[7:0]))
        else $error("byte subtract did not wrap");
    a_usat_byte: assert property (@(posedge clk) disable iff (rst)
        op_valid && op_code == psr_pkg::PSR_OP_ADDUS &&
        op_lane == psr_pkg::PSR_LANE_B && (9'(alu_bus.src_a[7:0]) +
        9'(alu_bus.src_b[7:0])) > 9'h0ff
        |-> alu_bus.result[7:0] == 8'hff)
        else $error("unsigned byte add did not clamp");
    a_sat_word_lo: assert property (@(posedge clk) disable iff (rst)
        op_valid && op_code == psr_pkg::PSR_OP_ADDS &&
        op_lane == psr_pkg::PSR_LANE_W && alu_bus.src_a[15] &&
        alu_bus.src_b[15] && (17'(alu_bus.src_a[15:0]) +
        17'(alu_bus.src_b[15:0])) < 17'h1_8000
        |-> alu_bus.result[15:0] == psr_pkg::SW_MIN)
        else $error("signed word add did not clamp low");
    a_sat_dword_hi: assert property (@(posedge clk) disable iff (rst)
        op_valid && op_code == psr_pkg::PSR_OP_ADDS &&
        op_lane == psr_pkg::PSR_LANE_D && !alu_bus.src_a[31] &&
        !alu_bus.src_b[31] && (33'(alu_bus.src_a[31:0]) +
        33'(alu_bus.src_b[31:0])) > 33'h0_7fff_ffff
        |-> alu_bus.result[31:0] == psr_pkg::SD_MAX)
        else $error("signed doubleword add did not clamp high");

    // carries stay inside their own lane
    a_word_carry: assert property (@(posedge clk) disable iff (rst)
        op_valid && op_code == psr_pkg::PSR_OP_ADD &&
        op_lane == psr_pkg::PSR_LANE_W
        |-> alu_bus.result[31:16] ==
            16'(alu_bus.src_a[31:16] + alu_bus.src_b[31:16]))
        else $error("word lane carry leaked");
    a_dword_carry: assert property (@(posedge clk) disable iff (rst)
        op_valid && op_code == psr_pkg::PSR_OP_ADD &&
        op_lane == psr_pkg::PSR_LANE_D
        |-> alu_bus.result[63:32] ==
            32'(alu_bus.src_a[63:32] + alu_bus.src_b[63:32]))
        else $error("doubleword lane carry leaked");

    // write and read paths
    a_op_write: assert property (@(posedge clk) disable iff (rst)
        op_valid
        |=> store_reg[$past(op_dst)] == $past(alu_bus.result))
        else $error("operation result not written whole");
    a_read_full: assert property (@(posedge clk) disable iff (rst)
        !$past(rd_half)
        |-> rd_data == $past(store_reg[rd_idx]))
        else $error("full read differs from storage");
    a_read_half: assert property (@(posedge clk) disable iff (rst)
        $past(rd_half)
        |-> rd_data[63:32] == 32'h0000_0000)
        else $error("half read upper half not clear");
    a_fp_read: assert property (@(posedge clk) disable iff (rst)
        1'b1 |-> fp_rd_data == $past(store_reg[fp_rd_idx]))
        else $error("fp view read differs from storage");
endmodule : psr_regfile
`default_nettype wire

// ### verif/psr_issue_model.sv
// partner: issue and load/store side driving the packed register file
`default_nettype none
module psr_issue_model
(
    // clock
    input wire logic clk,
    // operation issue
    output logic op_valid,
    output psr_pkg::psr_op_t op_code,
    output psr_pkg::psr_lane_t op_lane,
    output logic [2:0] op_dst,
    output logic [2:0] op_src,
    output logic op_src_mem,
    output logic [63:0] op_mem_data,
    // moves and fp view writes
    output logic mv_valid,
    output logic mv_half,
    output logic [2:0] mv_dst,
    output logic [63:0] mv_data,
    output logic fp_wr,
    output logic [2:0] fp_idx,
    output logic [63:0] fp_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // quiet bus at time zero
    initial
    begin
        {op_valid, op_dst, op_src, op_src_mem, op_mem_data} = '0;
        {mv_valid, mv_half, mv_dst, mv_data, fp_wr, fp_idx, fp_wdata} = '0;
        op_code = psr_pkg::PSR_OP_ADD;
        op_lane = psr_pkg::PSR_LANE_B;
    end
    // tasks are called just after a rising edge
    task put_op(psr_pkg::psr_op_t c, psr_pkg::psr_lane_t l,
        logic [2:0] d, logic [2:0] s, logic m, logic [63:0] md);
        op_valid <= 1'b1;
        op_code <= c;
        op_lane <= l;
        op_dst <= d;
        op_src <= s;
        op_src_mem <= m;
        op_mem_data <= md;
    endtask : put_op
    task put_mv(logic h, logic [2:0] d, logic [63:0] v);
        mv_valid <= 1'b1;
        mv_half <= h;
        mv_dst <= d;
        mv_data <= v;
    endtask : put_mv
    task put_fp(logic [2:0] i, logic [63:0] v);
        fp_wr <= 1'b1;
        fp_idx <= i;
        fp_wdata <= v;
    endtask : put_fp
    // released data lines show a changing pattern, not the old value
    task idle();
        op_valid <= 1'b0;
        mv_valid <= 1'b0;
        fp_wr <= 1'b0;
        op_mem_data <= ~op_mem_data;
        mv_data <= ~mv_data;
        fp_wdata <= ~fp_wdata;
    endtask : idle
endmodule : psr_issue_model
`default_nettype wire

// ### verif/packed_simd_register_file_tb.sv
// testbench: packed register file against a lane reference model
`default_nettype none
module packed_simd_register_file_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, op_valid, op_src_mem, mv_valid, mv_half, fp_wr, look;
    psr_pkg::psr_op_t op_code;
    psr_pkg::psr_lane_t op_lane;
    logic [2:0] op_dst, op_src, mv_dst, fp_idx, rd_idx, fp_rd_idx;
    logic [63:0] op_mem_data, mv_data, fp_wdata, rd_data, fp_rd_data, v, a, b;
    logic [7:0] rd_bytes [8];
    logic [63:0] ref_reg [8];
    logic [63:0] q [$];
    logic [63:0] qd [$];
    logic rd_half;
    int num_errors = 0;
    int total_checks = 0;
    // ************************************************************
    // clock, design and partner
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    psr_regfile i_dut (.clk(clk), .rst(rst), .op_valid(op_valid),
        .op_code(op_code), .op_lane(op_lane), .op_dst(op_dst),
        .op_src(op_src), .op_src_mem(op_src_mem), .op_mem_data(op_mem_data),
        .mv_valid(mv_valid), .mv_half(mv_half), .mv_dst(mv_dst),
        .mv_data(mv_data), .fp_wr(fp_wr), .fp_idx(fp_idx),
        .fp_wdata(fp_wdata), .rd_idx(rd_idx), .rd_half(rd_half),
        .rd_data(rd_data), .rd_bytes(rd_bytes), .fp_rd_idx(fp_rd_idx),
        .fp_rd_data(fp_rd_data));
    psr_issue_model i_iss (.clk(clk), .op_valid(op_valid),
        .op_code(op_code), .op_lane(op_lane), .op_dst(op_dst),
        .op_src(op_src), .op_src_mem(op_src_mem), .op_mem_data(op_mem_data),
        .mv_valid(mv_valid), .mv_half(mv_half), .mv_dst(mv_dst),
        .mv_data(mv_data), .fp_wr(fp_wr), .fp_idx(fp_idx),
        .fp_wdata(fp_wdata));
    // ************************************************************
    // reference lane arithmetic and checking
    // ************************************************************
    function automatic longint clamp(longint s, longint lo, longint hi);
        return s > hi ? hi : (s < lo ? lo : s);
    endfunction : clamp
    function automatic logic [63:0] alu(psr_pkg::psr_op_t op,
        psr_pkg::psr_lane_t ln, logic [63:0] a, logic [63:0] b);
        int w;
        logic [63:0] m, r, la, lb;
        longint x, y, sx, sy, s, hi;
        case (op)
            psr_pkg::PSR_OP_AND: return a & b;
            psr_pkg::PSR_OP_ANDN: return ~a & b;
            psr_pkg::PSR_OP_OR: return a | b;
            psr_pkg::PSR_OP_XOR: return a ^ b;
            default: ;
        endcase
        w = 8 << ln;
        m = (w == 64) ? '1 : (64'h1 << w) - 64'h1;
        r = '0;
        hi = (longint'(1) << (w - 1)) - 1;
        for (int i = 0; i < 64 / w; i++)
        begin
            la = (a >> (i * w)) & m;
            lb = (b >> (i * w)) & m;
            x = longint'(la);
            y = longint'(lb);
            sx = la[w - 1] ? x - (longint'(1) << w) : x;
            sy = lb[w - 1] ? y - (longint'(1) << w) : y;
            case (op)
                psr_pkg::PSR_OP_SUB: s = x - y;
                psr_pkg::PSR_OP_ADDS: s = clamp(sx + sy, -hi - 1, hi);
                psr_pkg::PSR_OP_SUBS: s = clamp(sx - sy, -hi - 1, hi);
                psr_pkg::PSR_OP_ADDUS: s = clamp(x + y, 0, longint'(m));
                psr_pkg::PSR_OP_SUBUS: s = clamp(x - y, 0, longint'(m));
                psr_pkg::PSR_OP_CMPEQ: s = (x == y) ? -1 : 0;
                psr_pkg::PSR_OP_CMPGT: s = (sx > sy) ? -1 : 0;
                default: s = x + y;
            endcase
            r = r | ((64'(s) & m) << (i * w));
        end
        return r;
    endfunction : alu
    task check(string name, logic [63:0] seen, logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task tally_and_finish();
        if (num_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    // read both views of one register, expectation noted in the queue
    task rd(logic [2:0] i, logic h = 1'b0);
        @(posedge clk);
        rd_idx <= i;
        rd_half <= h;
        fp_rd_idx <= i;
        @(posedge clk);
        look <= 1'b1;
        q.push_back(ref_reg[i]);
        qd.push_back(h ? {32'h0000_0000, ref_reg[i][31:0]} : ref_reg[i]);
        @(posedge clk);
        look <= 1'b0;
    endtask : rd
    // monitor: compare settled outputs with the oldest note
    always @(negedge clk)
    begin
        if (look)
        begin
            for (int j = 0; j < 8; j++)
                v[j * 8 +: 8] = rd_bytes[j];
            check("rd_data", rd_data, qd.pop_front());
            check("fp_rd_data", fp_rd_data, q[0]);
            check("rd_bytes", v, q.pop_front());
        end
    end
    // watchdog against a hung run
    initial
    begin
        #100000;
        num_errors++;
        tally_and_finish();
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        {rst, look, rd_half, rd_idx, fp_rd_idx} = '0;
        void'($urandom(19));
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            ref_reg[i] = '0;
            rd(i[2:0]);
        end
        // boundary lanes, then random, then memory operand
        for (int p = 0; p < 3; p++)
            for (int o = 0; o < 12; o++)
                for (int l = 0; l < 4; l++)
                begin
                    if (l == 3 && !(o == 0 || (o >= 6 && o <= 9)))
                        continue;
                    a = p == 0 ? 64'h7f80_00ff_7fff_8000 : {$urandom, $urandom};
                    b = p == 0 ? 64'h01ff_0101_0001_ffff : {$urandom, $urandom};
                    @(posedge clk);
                    i_iss.put_mv(1'b0, 3'h1, a);
                    @(posedge clk);
                    i_iss.put_mv(1'b0, 3'h2, b);
                    @(posedge clk);
                    i_iss.put_op(psr_pkg::psr_op_t'(o), psr_pkg::psr_lane_t'(l),
                        3'h1, 3'h2, p == 2, ~b);
                    @(posedge clk);
                    i_iss.idle();
                    ref_reg[2] = b;
                    ref_reg[1] = alu(psr_pkg::psr_op_t'(o),
                        psr_pkg::psr_lane_t'(l), a, p == 2 ? ~b : b);
                    rd(3'h1);
                end
        // half move, fp view write, same-cycle writes
        a = {$urandom, $urandom};
        b = {$urandom, $urandom};
        @(posedge clk);
        i_iss.put_mv(1'b1, 3'h3, a);
        i_iss.put_fp(3'h4, b);
        @(posedge clk);
        i_iss.idle();
        ref_reg[3] = {32'h0000_0000, a[31:0]};
        ref_reg[4] = b;
        rd(3'h3);
        rd(3'h4);
        @(posedge clk);
        i_iss.put_op(psr_pkg::PSR_OP_ADD, psr_pkg::PSR_LANE_B, 3'h4, 3'h4,
            1'b0, a);
        i_iss.put_mv(1'b0, 3'h4, a);
        i_iss.put_fp(3'h4, a);
        @(posedge clk);
        i_iss.put_mv(1'b0, 3'h5, b);
        i_iss.put_fp(3'h5, a);
        @(posedge clk);
        i_iss.idle();
        // the add stays valid for two edges, so it runs twice on reg 4
        a = alu(psr_pkg::PSR_OP_ADD, psr_pkg::PSR_LANE_B, b, b);
        ref_reg[4] = alu(psr_pkg::PSR_OP_ADD, psr_pkg::PSR_LANE_B, a, a);
        ref_reg[5] = b;
        rd(3'h4);
        rd(3'h4, 1'b1);
        rd(3'h5);
        repeat (2) @(posedge clk);
        tally_and_finish();
    end
endmodule : packed_simd_register_file_tb
`default_nettype wire
